// ---- verilog/charger_cfg_pkg.sv ----
`default_nettype none
package charger_cfg_pkg;
	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [7:0] ADDR_CHARGE_CURRENT = 8'h05;
	localparam logic [7:0] ADDR_CV_THRESHOLD   = 8'h06;
	localparam logic [7:0] ADDR_HEALTH_SINK    = 8'h07;
	localparam logic [7:0] ADDR_SOFT_RESET     = 8'h08;
	localparam logic [7:0] ADDR_NULL           = 8'hFF;
	localparam logic [7:0] SOFT_RESET_KEY      = 8'h00;
	localparam logic [4:0] CHARGE_CODE_RESET   = 5'h00;
	localparam logic [4:0] CV_CODE_RESET       = 5'h00;
	localparam logic [3:0] SINK_CODE_RESET     = 4'h0;
	localparam logic [7:0] REG_ADDR_RESET      = 8'h00;
	localparam logic [3:0] BITS_PER_BYTE       = 4'h8;
	// Arbitrary bus address
	localparam logic [6:0] DEFAULT_SLAVE_ADDR  = 7'h2A;
	// ----------------------------------------
	// Analog scaling
	// ----------------------------------------
	localparam logic [4:0]  CHG_SAT_CODE = 5'h13;
	localparam logic [10:0] CHG_STEP_MA  = 11'h032;
	localparam logic [10:0] CHG_MAX_MA   = 11'h3E8;
	localparam logic [4:0]  CV_TOP_CODE  = 5'h1F;
	localparam logic [12:0] CV_BASE_MV   = 13'h0BB8;
	localparam logic [12:0] CV_STEP_MV   = 13'h0064;
	localparam logic [12:0] CV_TOP_MV    = 13'h1B58;
	localparam logic [11:0] SINK_STEP_MA = 12'h07D;
	localparam logic [11:0] SINK_MAX_MA  = 12'h7D0;
	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [3:0] {
		IDLE      = 4'h0,
		ADDR      = 4'h1,
		ADDR_ACK  = 4'h3,
		REG       = 4'h2,
		REG_ACK   = 4'h6,
		WDATA     = 4'h7,
		WDATA_ACK = 4'h5,
		RDATA     = 4'h4,
		RDATA_ACK = 4'hC
	} slave_state_e;
	typedef struct packed {
		logic [4:0] chargeCode;
		logic [4:0] cvCode;
		logic [3:0] sinkCode;
	} fuse_defaults_s;
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] data;
	} write_req_s;
	typedef struct packed {
		logic [4:0]  fastChargeCurrentCode;
		logic [10:0] chargeCurrentMa;
		logic [4:0]  cvVoltageCode;
		logic [12:0] cvMillivolts;
		logic [3:0]  activeSinkCode;
		logic [11:0] sinkCurrentMa;
	} charger_setting_s;
	// ----------------------------------------
	// Scaling functions
	// ----------------------------------------
	function automatic logic [10:0] chargeMa(input logic [4:0] c);
		logic [10:0] steps;
		steps = {6'h00, c} + 11'h001;
		chargeMa = (c >= CHG_SAT_CODE) ? CHG_MAX_MA : 11'(steps * CHG_STEP_MA);
	endfunction
	function automatic logic [12:0] cvMillivolts(input logic [4:0] c);
		cvMillivolts = (c == CV_TOP_CODE) ? CV_TOP_MV
			: 13'(CV_BASE_MV + {8'h00, c} * CV_STEP_MV);
	endfunction
	function automatic logic [11:0] sinkMa(input logic [3:0] c);
		logic [11:0] steps;
		steps = {8'h00, c} + 12'h001;
		sinkMa = 12'(steps * SINK_STEP_MA);
	endfunction
endpackage
`default_nettype wire

// ---- verilog/charger_reg_bank.sv ----
`timescale 1ns/100ps
`default_nettype none
module charger_reg_bank (
	input  wire logic                              clk,
	input  wire logic                              rst_b,
	input  wire logic                              softRst,
	input  wire logic                              wrEn,
	input  wire charger_cfg_pkg::write_req_s       wrReq,
	input  wire logic [7:0]                        rdAddr,
	input  wire charger_cfg_pkg::fuse_defaults_s   fuse,
	input  wire logic                              overrideSel,
	output var  logic [7:0]                        rdData,
	output var  charger_cfg_pkg::charger_setting_s setting
);
	logic [4:0] chargeCode_reg;
	logic [4:0] cvCode_reg;
	logic [3:0] progSink_reg;
	logic       chargeWritten_reg;
	logic       cvWritten_reg;
	logic [4:0] chargeEff;
	logic [4:0] cvEff;
	logic [3:0] activeSink;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	// ----------------------------------------
	// Stored codes
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			chargeCode_reg    <= charger_cfg_pkg::CHARGE_CODE_RESET;
			cvCode_reg        <= charger_cfg_pkg::CV_CODE_RESET;
			progSink_reg      <= charger_cfg_pkg::SINK_CODE_RESET;
			chargeWritten_reg <= 1'b0;
			cvWritten_reg     <= 1'b0;
		end
		else if (softRst)
		begin
			chargeCode_reg    <= charger_cfg_pkg::CHARGE_CODE_RESET;
			cvCode_reg        <= charger_cfg_pkg::CV_CODE_RESET;
			progSink_reg      <= charger_cfg_pkg::SINK_CODE_RESET;
			chargeWritten_reg <= 1'b0;
			cvWritten_reg     <= 1'b0;
		end
		else if (wrEn)
		begin
			case (wrReq.addr)
				charger_cfg_pkg::ADDR_CHARGE_CURRENT:
				begin
					chargeCode_reg    <= wrReq.data[4:0];
					chargeWritten_reg <= 1'b1;
				end
				charger_cfg_pkg::ADDR_CV_THRESHOLD:
				begin
					cvCode_reg    <= wrReq.data[4:0];
					cvWritten_reg <= 1'b1;
				end
				charger_cfg_pkg::ADDR_HEALTH_SINK: progSink_reg <= wrReq.data[3:0];
				default: ;
			endcase
		end
	end
	// Fuse values show until software writes the field; the sink field follows overrideSel instead
	assign chargeEff  = chargeWritten_reg ? chargeCode_reg : fuse.chargeCode;
	assign cvEff      = cvWritten_reg ? cvCode_reg : fuse.cvCode;
	assign activeSink = overrideSel ? progSink_reg : fuse.sinkCode;
	// ----------------------------------------
	// Read data and settings
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			rdData <= 8'h00;
		else
		begin
			case (rdAddr)
				charger_cfg_pkg::ADDR_CHARGE_CURRENT: rdData <= {3'h0, chargeEff};
				charger_cfg_pkg::ADDR_CV_THRESHOLD:   rdData <= {3'h0, cvEff};
				charger_cfg_pkg::ADDR_HEALTH_SINK:    rdData <= {activeSink, progSink_reg};
				default:                              rdData <= 8'h00;
			endcase
		end
	end
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			setting <= '0;
		else
		begin
			setting.fastChargeCurrentCode <= chargeEff;
			setting.chargeCurrentMa       <= charger_cfg_pkg::chargeMa(chargeEff);
			setting.cvVoltageCode         <= cvEff;
			setting.cvMillivolts          <= charger_cfg_pkg::cvMillivolts(cvEff);
			setting.activeSinkCode        <= activeSink;
			setting.sinkCurrentMa         <= charger_cfg_pkg::sinkMa(activeSink);
		end
	end
	// ----------------------------------------
	// Checks
	// ----------------------------------------
	property p_chargeSat;
		chargeEff >= charger_cfg_pkg::CHG_SAT_CODE |=> setting.chargeCurrentMa == 11'h3E8;
	endproperty
	a_chargeSat: assert property (p_chargeSat) else $error("charge current not saturated");
	property p_cvTop;
		cvEff == 5'h1F |=> setting.cvMillivolts == 13'h1B58;
	endproperty
	a_cvTop: assert property (p_cvTop) else $error("top voltage code wrong");
	property p_fuseSink;
		!overrideSel |=> setting.activeSinkCode == $past(fuse.sinkCode);
	endproperty
	a_fuseSink: assert property (p_fuseSink) else $error("sink code not from fuse");
	property p_sinkReadback;
		rdAddr == charger_cfg_pkg::ADDR_HEALTH_SINK && !softRst
			|=> rdData == {$past(activeSink), $past(progSink_reg)};
	endproperty
	a_sinkReadback: assert property (p_sinkReadback) else $error("sink readback wrong");
	property p_sinkWrite;
		wrEn && !softRst && wrReq.addr == charger_cfg_pkg::ADDR_HEALTH_SINK
			|=> progSink_reg == $past(wrReq.data[3:0]) && $stable({chargeCode_reg, cvCode_reg});
	endproperty
	a_sinkWrite: assert property (p_sinkWrite) else $error("sink write lost");
	property p_nullWrite;
		wrEn && !softRst && wrReq.addr == charger_cfg_pkg::ADDR_NULL
			|=> $stable({chargeCode_reg, cvCode_reg, progSink_reg, chargeWritten_reg, cvWritten_reg});
	endproperty
	a_nullWrite: assert property (p_nullWrite) else $error("null write changed state");
	property p_nullRead;
		rdAddr == charger_cfg_pkg::ADDR_NULL |=> rdData == 8'h00;
	endproperty
	a_nullRead: assert property (p_nullRead) else $error("null read not zero");
	property p_fuseUntilWrite;
		!chargeWritten_reg && rdAddr == charger_cfg_pkg::ADDR_CHARGE_CURRENT
			|=> rdData[4:0] == $past(fuse.chargeCode);
	endproperty
	a_fuseUntilWrite: assert property (p_fuseUntilWrite) else $error("fuse default not read");
	property p_sinkScale;
		setting.activeSinkCode == 4'hF |-> setting.sinkCurrentMa == 12'h7D0;
	endproperty
	a_sinkScale: assert property (p_sinkScale) else $error("sink scale wrong");
endmodule
`default_nettype wire

// ---- verilog/charger_config_regs.sv ----
`timescale 1ns/100ps
`default_nettype none
module charger_config_regs #(
	parameter logic [6:0] SLAVE_ADDR = charger_cfg_pkg::DEFAULT_SLAVE_ADDR
) (
	input  wire logic                              clk,
	input  wire logic                              rst_b,
	input  wire logic                              sclIn,
	input  wire logic                              sdaIn,
	output var  logic                              sdaOut,
	output var  logic                              sdaOe,
	input  wire logic                              sinkTestEnable,
	input  wire logic                              sinkOverrideSelect,
	input  wire charger_cfg_pkg::fuse_defaults_s   fuse,
	output var  charger_cfg_pkg::charger_setting_s setting,
	output var  logic                              sinkMeasureOn,
	output var  logic                              softResetPulse
);
	if (SLAVE_ADDR[6:3] == 4'h0 || SLAVE_ADDR[6:3] == 4'hF)
		$error("slave address falls in a reserved block");

	charger_cfg_pkg::slave_state_e state_reg;
	charger_cfg_pkg::write_req_s   wrReq_reg;
	logic       sclSync1_reg;
	logic       sclSync2_reg;
	logic       sclPrev_reg;
	logic       sdaSync1_reg;
	logic       sdaSync2_reg;
	logic       sdaPrev_reg;
	logic       sclRise;
	logic       sclFall;
	logic       startSeen;
	logic       stopSeen;
	logic       byteDone;
	logic [3:0] bitCnt_reg;
	logic [7:0] shift_reg;
	logic [7:0] txShift_reg;
	logic [7:0] regAddr_reg;
	logic       readMode_reg;
	logic       masterAck_reg;
	logic       wrEn_reg;
	logic       softRst_reg;
	logic       keyWrite;
	logic [7:0] rdData;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	// Idle bus is high, so the chain resets high to avoid a false start
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			sclSync1_reg <= 1'b1;
			sclSync2_reg <= 1'b1;
			sclPrev_reg  <= 1'b1;
			sdaSync1_reg <= 1'b1;
			sdaSync2_reg <= 1'b1;
			sdaPrev_reg  <= 1'b1;
		end
		else
		begin
			sclSync1_reg <= sclIn;
			sclSync2_reg <= sclSync1_reg;
			sclPrev_reg  <= sclSync2_reg;
			sdaSync1_reg <= sdaIn;
			sdaSync2_reg <= sdaSync1_reg;
			sdaPrev_reg  <= sdaSync2_reg;
		end
	end
	assign sclRise   = sclSync2_reg && !sclPrev_reg;
	assign sclFall   = !sclSync2_reg && sclPrev_reg;
	assign startSeen = sclSync2_reg && sclPrev_reg && !sdaSync2_reg && sdaPrev_reg;
	assign stopSeen  = sclSync2_reg && sclPrev_reg && sdaSync2_reg && !sdaPrev_reg;
	assign byteDone  = bitCnt_reg == charger_cfg_pkg::BITS_PER_BYTE;
	assign keyWrite  = sclFall && state_reg == charger_cfg_pkg::WDATA_ACK
		&& regAddr_reg == charger_cfg_pkg::ADDR_SOFT_RESET
		&& shift_reg == charger_cfg_pkg::SOFT_RESET_KEY;
	// ----------------------------------------
	// Serial protocol engine
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state_reg     <= charger_cfg_pkg::IDLE;
			bitCnt_reg    <= 4'h0;
			shift_reg     <= 8'h00;
			txShift_reg   <= 8'h00;
			regAddr_reg   <= charger_cfg_pkg::REG_ADDR_RESET;
			readMode_reg  <= 1'b0;
			masterAck_reg <= 1'b0;
		end
		else if (softRst_reg)
		begin
			state_reg     <= charger_cfg_pkg::IDLE;
			bitCnt_reg    <= 4'h0;
			shift_reg     <= 8'h00;
			txShift_reg   <= 8'h00;
			regAddr_reg   <= charger_cfg_pkg::REG_ADDR_RESET;
			readMode_reg  <= 1'b0;
			masterAck_reg <= 1'b0;
		end
		else if (startSeen)
		begin
			state_reg  <= charger_cfg_pkg::ADDR;
			bitCnt_reg <= 4'h0;
		end
		else if (stopSeen)
			state_reg <= charger_cfg_pkg::IDLE;
		else if (sclRise)
		begin
			case (state_reg)
				charger_cfg_pkg::ADDR, charger_cfg_pkg::REG,
				charger_cfg_pkg::WDATA, charger_cfg_pkg::RDATA:
				begin
					shift_reg  <= {shift_reg[6:0], sdaSync2_reg};
					bitCnt_reg <= bitCnt_reg + 4'h1;
				end
				charger_cfg_pkg::RDATA_ACK: masterAck_reg <= !sdaSync2_reg;
				default: ;
			endcase
		end
		else if (sclFall)
		begin
			case (state_reg)
				charger_cfg_pkg::ADDR:
				begin
					if (byteDone)
					begin
						bitCnt_reg   <= 4'h0;
						readMode_reg <= shift_reg[0];
						state_reg    <= (shift_reg[7:1] == SLAVE_ADDR)
							? charger_cfg_pkg::ADDR_ACK : charger_cfg_pkg::IDLE;
					end
				end
				charger_cfg_pkg::ADDR_ACK:
				begin
					if (readMode_reg)
					begin
						state_reg   <= charger_cfg_pkg::RDATA;
						txShift_reg <= rdData;
						regAddr_reg <= regAddr_reg + 8'h01;
					end
					else
						state_reg <= charger_cfg_pkg::REG;
				end
				charger_cfg_pkg::REG:
				begin
					if (byteDone)
					begin
						state_reg   <= charger_cfg_pkg::REG_ACK;
						bitCnt_reg  <= 4'h0;
						regAddr_reg <= shift_reg;
					end
				end
				charger_cfg_pkg::REG_ACK: state_reg <= charger_cfg_pkg::WDATA;
				charger_cfg_pkg::WDATA:
				begin
					if (byteDone)
					begin
						state_reg  <= charger_cfg_pkg::WDATA_ACK;
						bitCnt_reg <= 4'h0;
					end
				end
				charger_cfg_pkg::WDATA_ACK:
				begin
					state_reg   <= charger_cfg_pkg::WDATA;
					regAddr_reg <= regAddr_reg + 8'h01;
				end
				charger_cfg_pkg::RDATA:
				begin
					if (byteDone)
					begin
						state_reg  <= charger_cfg_pkg::RDATA_ACK;
						bitCnt_reg <= 4'h0;
					end
					else if (bitCnt_reg != 4'h0)
						txShift_reg <= {txShift_reg[6:0], 1'b0};
				end
				charger_cfg_pkg::RDATA_ACK:
				begin
					if (masterAck_reg)
					begin
						state_reg   <= charger_cfg_pkg::RDATA;
						txShift_reg <= rdData;
						regAddr_reg <= regAddr_reg + 8'h01;
					end
					else
						state_reg <= charger_cfg_pkg::IDLE;
				end
				default: state_reg <= charger_cfg_pkg::IDLE;
			endcase
		end
	end
	// ----------------------------------------
	// Write and soft reset strobes
	// ----------------------------------------
	// Reset lands as the data acknowledge ends, so the host sees its ACK
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			wrEn_reg    <= 1'b0;
			wrReq_reg   <= '0;
			softRst_reg <= 1'b0;
		end
		else
		begin
			softRst_reg <= keyWrite && !softRst_reg;
			wrEn_reg    <= sclFall && state_reg == charger_cfg_pkg::WDATA_ACK
				&& !keyWrite && !softRst_reg;
			wrReq_reg   <= '{addr: regAddr_reg, data: shift_reg};
		end
	end
	// ----------------------------------------
	// Pin and status outputs
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			sdaOut <= 1'b0;
			sdaOe  <= 1'b0;
		end
		else
		begin
			sdaOut <= 1'b0;
			sdaOe  <= !softRst_reg && (state_reg == charger_cfg_pkg::ADDR_ACK
				|| state_reg == charger_cfg_pkg::REG_ACK
				|| state_reg == charger_cfg_pkg::WDATA_ACK
				|| (state_reg == charger_cfg_pkg::RDATA && !txShift_reg[7]));
		end
	end
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			sinkMeasureOn  <= 1'b0;
			softResetPulse <= 1'b0;
		end
		else
		begin
			sinkMeasureOn  <= sinkTestEnable && !softRst_reg;
			softResetPulse <= softRst_reg;
		end
	end
	charger_reg_bank charger_reg_bank_inst (
		.clk         (clk),
		.rst_b       (rst_b),
		.softRst     (softRst_reg),
		.wrEn        (wrEn_reg),
		.wrReq       (wrReq_reg),
		.rdAddr      (regAddr_reg),
		.fuse        (fuse),
		.overrideSel (sinkOverrideSelect),
		.rdData      (rdData),
		.setting     (setting)
	);
	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence s_keyByte;
		keyWrite && !softRst_reg;
	endsequence
	sequence s_resetDone;
		softRst_reg ##1 (state_reg == charger_cfg_pkg::IDLE && softResetPulse && !sdaOe);
	endsequence
	property p_softReset;
		s_keyByte |=> s_resetDone;
	endproperty
	a_softReset: assert property (p_softReset) else $error("soft reset not applied");
	property p_badKey;
		sclFall && state_reg == charger_cfg_pkg::WDATA_ACK && shift_reg != 8'h00
			|=> !softRst_reg;
	endproperty
	a_badKey: assert property (p_badKey) else $error("reset on wrong data");
	property p_resetClears;
		softRst_reg |=> regAddr_reg == 8'h00 && bitCnt_reg == 4'h0 && !wrEn_reg;
	endproperty
	a_resetClears: assert property (p_resetClears) else $error("defaults not reloaded");
	property p_sinkEnable;
		!sinkTestEnable[*2] |=> !sinkMeasureOn;
	endproperty
	a_sinkEnable: assert property (p_sinkEnable) else $error("sink on without enable");
	property p_ackDrive;
		(state_reg == charger_cfg_pkg::WDATA_ACK && !softRst_reg)[*2] |-> sdaOe && !sdaOut;
	endproperty
	a_ackDrive: assert property (p_ackDrive) else $error("data byte not acknowledged");
endmodule
`default_nettype wire

// ---- testbench/i2c_host_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module i2c_host_model #(
	parameter logic [6:0] DEV_ADDR = 7'h2A
) (
	input  wire logic clk,
	input  wire logic sdaLine,
	output var  logic sclOut,
	output var  logic hostOe
);
	// ----------------------------------------
	// Bit timing
	// ----------------------------------------
	// Clocks per SCL phase; the bench raises it to act as a slow host
	int halfTicks = 12;
	initial
	begin
		sclOut = 1'b1;
		hostOe = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	// SDA moves mid low phase only, clear of the synchronised SCL edges
	task automatic bitOut(input logic b, output logic seen);
		tick(halfTicks / 2);
		hostOe <= ~b;
		tick(halfTicks / 2);
		sclOut <= 1'b1;
		tick(halfTicks);
		seen = sdaLine;
		sclOut <= 1'b0;
	endtask
	task automatic startCond();
		tick(halfTicks / 2);
		hostOe <= 1'b0;
		tick(halfTicks / 2);
		sclOut <= 1'b1;
		tick(halfTicks);
		hostOe <= 1'b1;
		tick(halfTicks);
		sclOut <= 1'b0;
	endtask
	task automatic stopCond();
		tick(halfTicks / 2);
		hostOe <= 1'b1;
		tick(halfTicks / 2);
		sclOut <= 1'b1;
		tick(halfTicks);
		hostOe <= 1'b0;
		tick(halfTicks);
	endtask
	// ----------------------------------------
	// Byte and transfer level
	// ----------------------------------------
	task automatic sendByte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			bitOut(d[i], s);
		bitOut(1'b1, s);
		ack = ~s;
	endtask
	task automatic recvByte(input logic nack, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--)
			bitOut(1'b1, d[i]);
		bitOut(nack, s);
	endtask
	task automatic writeReg(input logic [7:0] r, input logic [7:0] v, output logic ack);
		logic a0;
		logic a1;
		logic a2;
		startCond();
		sendByte({DEV_ADDR, 1'b0}, a0);
		sendByte(r, a1);
		sendByte(v, a2);
		stopCond();
		ack = a0 & a1 & a2;
	endtask
	// Pointer write, repeated start, one byte read, host NACK ends it
	task automatic readReg(input logic [7:0] r, output logic [7:0] v, output logic ack);
		logic a0;
		logic a1;
		logic a2;
		startCond();
		sendByte({DEV_ADDR, 1'b0}, a0);
		sendByte(r, a1);
		startCond();
		sendByte({DEV_ADDR, 1'b1}, a2);
		recvByte(1'b1, v);
		stopCond();
		ack = a0 & a1 & a2;
	endtask
endmodule
`default_nettype wire

// ---- testbench/test_charger_config_regs.sv ----
`timescale 1ns/100ps
`default_nettype none
module test_charger_config_regs;
	logic                              clk;
	logic                              rst_b;
	logic                              sclLine;
	logic                              hostOe;
	logic                              sdaOut;
	logic                              sdaOe;
	wire logic                         sdaLine;
	logic                              sinkTestEnable;
	logic                              sinkOverrideSelect;
	charger_cfg_pkg::fuse_defaults_s   fuse;
	charger_cfg_pkg::charger_setting_s setting;
	logic                              sinkMeasureOn;
	logic                              softResetPulse;
	int                                fail_count = 0;
	int                                checks_done = 0;
	int                                pulseCount = 0;
	logic [7:0]                        d;
	// Pull-up: released by both parties reads high
	assign sdaLine = ~hostOe & ~(sdaOe & ~sdaOut);
	always #4 clk = ~clk;
	always @(posedge clk)
		if (softResetPulse === 1'b1)
			pulseCount++;
	charger_config_regs charger_config_regs_inst (
		.clk               (clk),
		.rst_b             (rst_b),
		.sclIn             (sclLine),
		.sdaIn             (sdaLine),
		.sdaOut            (sdaOut),
		.sdaOe             (sdaOe),
		.sinkTestEnable    (sinkTestEnable),
		.sinkOverrideSelect(sinkOverrideSelect),
		.fuse              (fuse),
		.setting           (setting),
		.sinkMeasureOn     (sinkMeasureOn),
		.softResetPulse    (softResetPulse)
	);
	i2c_host_model #(
		.DEV_ADDR(charger_cfg_pkg::DEFAULT_SLAVE_ADDR)
	) i2c_host_model_inst (
		.clk    (clk),
		.sdaLine(sdaLine),
		.sclOut (sclLine),
		.hostOe (hostOe)
	);
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] r, input logic [7:0] v);
		logic a;
		i2c_host_model_inst.writeReg(r, v, a);
		tick(4);
		check("wrAck", 16'(a), 16'h0001);
	endtask
	task automatic rd(input logic [7:0] r, output logic [7:0] v);
		logic a;
		i2c_host_model_inst.readReg(r, v, a);
	endtask
	function automatic logic [15:0] chgMa(input logic [4:0] c);
		return (c >= 5'h13) ? 16'h03E8 : 16'((16'(c) + 16'h0001) * 16'h0032);
	endfunction
	function automatic logic [15:0] cvMv(input logic [4:0] c);
		return (c == 5'h1F) ? 16'h1B58 : 16'(16'h0BB8 + 16'(c) * 16'h0064);
	endfunction
	function automatic logic [15:0] sinkMa(input logic [3:0] c);
		return 16'((16'(c) + 16'h0001) * 16'h007D);
	endfunction
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic test_defaults();
		rd(charger_cfg_pkg::ADDR_CHARGE_CURRENT, d);
		check("chgRead", 16'(d), 16'(fuse.chargeCode));
		rd(charger_cfg_pkg::ADDR_CV_THRESHOLD, d);
		check("cvRead", 16'(d), 16'(fuse.cvCode));
		check("cvMv", 16'(setting.cvMillivolts), cvMv(fuse.cvCode));
		check("sinkMa", 16'(setting.sinkCurrentMa), sinkMa(fuse.sinkCode));
		$display("test_defaults done");
	endtask
	// Boundary codes of both scales, including saturation and the top code
	task automatic test_codes();
		logic [4:0] codes [7];
		codes = '{5'h00, 5'h01, 5'h12, 5'h13, 5'h1D, 5'h1E, 5'h1F};
		foreach (codes[i])
		begin
			wr(charger_cfg_pkg::ADDR_CHARGE_CURRENT, 8'(codes[i]));
			wr(charger_cfg_pkg::ADDR_CV_THRESHOLD, 8'(codes[i]));
			check("chgCode", 16'(setting.fastChargeCurrentCode), 16'(codes[i]));
			check("chgMa", 16'(setting.chargeCurrentMa), chgMa(codes[i]));
			check("cvMv", 16'(setting.cvMillivolts), cvMv(codes[i]));
			check("cvCode", 16'(setting.cvVoltageCode), 16'(codes[i]));
			rd(charger_cfg_pkg::ADDR_CV_THRESHOLD, d);
			check("cvRead", 16'(d), 16'(codes[i]));
		end
		$display("test_codes done");
	endtask
	task automatic test_sink();
		// Programmed code goes in before the override is selected
		wr(charger_cfg_pkg::ADDR_HEALTH_SINK, 8'hA6);
		check("measOn", 16'(sinkMeasureOn), 16'h0000);
		rd(charger_cfg_pkg::ADDR_HEALTH_SINK, d);
		check("sinkRead", 16'(d), 16'({fuse.sinkCode, 4'h6}));
		check("active", 16'(setting.activeSinkCode), 16'(fuse.sinkCode));
		sinkOverrideSelect <= 1'b1;
		tick(3);
		check("active", 16'(setting.activeSinkCode), 16'h0006);
		check("sinkMa", 16'(setting.sinkCurrentMa), sinkMa(4'h6));
		rd(charger_cfg_pkg::ADDR_HEALTH_SINK, d);
		check("sinkRead", 16'(d), 16'h0066);
		sinkTestEnable <= 1'b1;
		tick(3);
		check("measOn", 16'(sinkMeasureOn), 16'h0001);
		sinkTestEnable <= 1'b0;
		i2c_host_model_inst.halfTicks = 40;
		wr(charger_cfg_pkg::ADDR_HEALTH_SINK, 8'h0F);
		i2c_host_model_inst.halfTicks = 12;
		check("measOn", 16'(sinkMeasureOn), 16'h0000);
		check("sinkMa", 16'(setting.sinkCurrentMa), 16'h07D0);
		sinkOverrideSelect <= 1'b0;
		tick(3);
		check("active", 16'(setting.activeSinkCode), 16'(fuse.sinkCode));
		$display("test_sink done");
	endtask
	task automatic test_null();
		charger_cfg_pkg::charger_setting_s snap;
		logic a;
		snap = setting;
		i2c_host_model_inst.writeReg(charger_cfg_pkg::ADDR_NULL, 8'h5A, a);
		tick(4);
		check("nullAck", 16'(a), 16'h0001);
		check("kept", 16'(setting !== snap), 16'h0000);
		rd(charger_cfg_pkg::ADDR_NULL, d);
		check("nullRead", 16'(d), 16'h0000);
		$display("test_null done");
	endtask
	task automatic test_soft_reset();
		int p;
		wr(charger_cfg_pkg::ADDR_CHARGE_CURRENT, 8'h03);
		wr(charger_cfg_pkg::ADDR_HEALTH_SINK, 8'h09);
		p = pulseCount;
		wr(charger_cfg_pkg::ADDR_SOFT_RESET, 8'h01);
		check("noPulse", 16'(pulseCount - p), 16'h0000);
		rd(charger_cfg_pkg::ADDR_CHARGE_CURRENT, d);
		check("chgKept", 16'(d), 16'h0003);
		wr(charger_cfg_pkg::ADDR_SOFT_RESET, 8'h00);
		check("pulse", 16'(pulseCount - p), 16'h0001);
		check("chgCode", 16'(setting.fastChargeCurrentCode), 16'(fuse.chargeCode));
		rd(charger_cfg_pkg::ADDR_CHARGE_CURRENT, d);
		check("chgRead", 16'(d), 16'(fuse.chargeCode));
		rd(charger_cfg_pkg::ADDR_HEALTH_SINK, d);
		check("sinkRead", 16'(d), 16'({fuse.sinkCode, 4'h0}));
		$display("test_soft_reset done");
	endtask
	// ----------------------------------------
	// Run control
	// ----------------------------------------
	task automatic end_of_test();
		$display("Comparisons %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial
	begin
		clk = 1'b0;
		rst_b = 1'b0;
		sinkTestEnable = 1'b0;
		sinkOverrideSelect = 1'b0;
		fuse = '{chargeCode: 5'h09, cvCode: 5'h0C, sinkCode: 4'h3};
		tick(16);
		rst_b <= 1'b1;
		tick(4);
		test_defaults();
		test_codes();
		test_sink();
		test_null();
		test_soft_reset();
		end_of_test();
	end
	// Roughly two and a quarter times the expected run length
	initial
	begin
		#560000;
		fail_count++;
		end_of_test();
	end
endmodule
`default_nettype wire
